// [emad_pkg.sv]
// Constants, codes and field layout shared by the addressing-mode decode block.
// How it works
// - A four-bit mode field sits at control bits six to three.
// - The mode decides each memory pin's role and static or dynamic RAM.
// - Hardware and software reset both clear the mode field to zero.
// - Mode 0000: absolute static RAM, fifteen address lines, no chip select, 32 K.
// - Mode 0000 holds chip select zero and address line fifteen high.
// - Mode 0000 row and column strobes act only for refresh.
// - Modes 0001 to 0011: relative static RAM with one, two or four selects.
// - Modes 0100 to 0111: relative dynamic RAM, eight to eleven lines, strobes.
// - Modes 1100 to 1111: as relative dynamic RAM but absolute addressing.
// - Absolute modes post-increment the base after every access of a word.
// - Code 011 counts as 16-bit when absolute, 24-bit when relative.
// - Absolute modes pack words contiguously without power-of-two slots.
// - Relative modes give each word a power-of-two slot.
// - Bus width bit clear selects 4 bits, set selects 8 bits.
// - Word length field selects 8, 16, 24, 12, 20 or 16/24; 100 and 111 reserved.
package emad_pkg;
	localparam int CSR_W    = 24;
	localparam int ADDR_W   = 24;
	localparam int CAP_W    = 23;
	localparam int BW_BIT   = 0;
	localparam int WLEN0_BIT = 1;
	localparam int WLEN1_BIT = 2;
	localparam int WLEN2_BIT = 16;
	localparam int MODE_LSB  = 3;
	localparam int MODE_MSB  = 6;
	localparam int CS2_SEL_BIT = 17;
	localparam int CS4_SEL_LSB = 15;
	localparam int LINE15_BIT  = 15;

	localparam logic [3:0] MODE_SRAM_ABS  = 4'h0;
	localparam logic [3:0] MODE_SRAM_CS1  = 4'h1;
	localparam logic [3:0] MODE_SRAM_CS2  = 4'h2;
	localparam logic [3:0] MODE_SRAM_CS4  = 4'h3;
	localparam logic [3:0] MODE_DRAM_REL8 = 4'h4;
	localparam logic [3:0] MODE_DRAM_ABS8 = 4'hC;
	localparam logic [1:0] MODE_RSV_TOP   = 2'h2;
	localparam logic [3:0] MODE_RST       = 4'h0;

	localparam logic [2:0] WL_8     = 3'h0;
	localparam logic [2:0] WL_16    = 3'h1;
	localparam logic [2:0] WL_24    = 3'h2;
	localparam logic [2:0] WL_16D24 = 3'h3;
	localparam logic [2:0] WL_12    = 3'h5;
	localparam logic [2:0] WL_20    = 3'h6;
	localparam logic [2:0] WL_RST   = 3'h0;

	localparam logic [4:0] LINES_SRAM_ABS = 5'h0F;
	localparam logic [4:0] LINES_SRAM_CS1 = 5'h12;
	localparam logic [4:0] LINES_SRAM_CS2 = 5'h11;
	localparam logic [4:0] LINES_SRAM_CS4 = 5'h0F;
	localparam logic [4:0] LINES_DRAM_MIN = 5'h08;

	localparam logic [4:0] RLOG_SRAM_ABS = 5'h0F;
	localparam logic [4:0] RLOG_SRAM_REL = 5'h12;
	localparam logic [4:0] RLOG_SRAM_CS4 = 5'h11;
	localparam logic [4:0] RLOG_DRAM_MIN = 5'h10;

	localparam logic [CAP_W-1:0] CAP_REL_EX  = 23'h0_4000;
	localparam logic [CAP_W-1:0] CAP_ABS_EX  = 23'h0_5555;
	localparam logic [CAP_W-1:0] CAP_D24_EX  = 23'h0_2000;

	typedef enum logic [1:0] {
		KIND_SRAM_ABS = 2'b00,
		KIND_SRAM_REL = 2'b01,
		KIND_DRAM_REL = 2'b11,
		KIND_DRAM_ABS = 2'b10
	} emad_kind_e;
endpackage : emad_pkg

// [emad_cap_if.sv]
// Interface that carries the latched configuration to the capacity calculator.
`timescale 1ns/1ps
interface emad_cap_if;
	logic [3:0]                 mode;
	logic                       bus_wide;
	logic [2:0]                 word_len;
	logic [emad_pkg::CAP_W-1:0] capacity;
	logic [2:0]                 accesses;
	modport calc (input mode, input bus_wide, input word_len, output capacity, output accesses);
	modport user (output mode, output bus_wide, output word_len, input capacity, input accesses);
endinterface : emad_cap_if

// [emad_capacity.sv]
// Word capacity and accesses per word for the selected mode, width and length.
`timescale 1ns/1ps
module emad_capacity (
	input  wire logic   clk,
	input  wire logic   rst_n,
	emad_cap_if.calc    cfg
);
	typedef struct packed {
		logic [emad_pkg::CAP_W-1:0] capacity;
		logic [2:0]                 accesses;
	} emad_cap_s;

	emad_cap_s              st;
	emad_cap_s              next_st;
	logic [2:0]             nib;
	logic [1:0]             slot;
	logic [4:0]             rlog;
	logic [emad_pkg::CAP_W-1:0] range;
	logic                   is_abs;
	logic                   bad;

	always_comb begin
		next_st = st;
		nib = 3'h0;
		slot = 2'h0;
		bad = 1'b0;
		// The 16/24 code costs four nibbles but claims an eight-nibble slot.
		case (cfg.word_len)
			emad_pkg::WL_8: begin
				nib = 3'h2;
				slot = 2'h1;
			end
			emad_pkg::WL_12: begin
				nib = 3'h3;
				slot = 2'h2;
			end
			emad_pkg::WL_16: begin
				nib = 3'h4;
				slot = 2'h2;
			end
			emad_pkg::WL_16D24: begin
				nib = 3'h4;
				slot = 2'h3;
			end
			emad_pkg::WL_20: begin
				nib = 3'h5;
				slot = 2'h3;
			end
			emad_pkg::WL_24: begin
				nib = 3'h6;
				slot = 2'h3;
			end
			default: bad = 1'b1;
		endcase
		if (cfg.bus_wide) begin
			nib = 3'((nib + 3'h1) >> 1);
			slot = slot - 2'h1;
		end
		is_abs = (cfg.mode == emad_pkg::MODE_SRAM_ABS) || (cfg.mode[3:2] == 2'h3);
		case (cfg.mode)
			emad_pkg::MODE_SRAM_ABS: rlog = emad_pkg::RLOG_SRAM_ABS;
			emad_pkg::MODE_SRAM_CS1: rlog = emad_pkg::RLOG_SRAM_REL;
			emad_pkg::MODE_SRAM_CS2: rlog = emad_pkg::RLOG_SRAM_REL;
			emad_pkg::MODE_SRAM_CS4: rlog = emad_pkg::RLOG_SRAM_CS4;
			default: rlog = emad_pkg::RLOG_DRAM_MIN + {2'h0, cfg.mode[1:0], 1'b0};
		endcase
		if (cfg.mode[3:2] == emad_pkg::MODE_RSV_TOP) begin
			bad = 1'b1;
		end
		range = emad_pkg::CAP_W'(1) << rlog;
		next_st.accesses = bad ? 3'h0 : nib;
		if (bad) begin
			next_st.capacity = '0;
		end else if (!is_abs) begin
			next_st.capacity = range >> slot;
		end else begin
			// Constant dividers only; packing leaves no slot padding.
			case (nib)
				3'h1: next_st.capacity = range;
				3'h2: next_st.capacity = range >> 1;
				3'h3: next_st.capacity = emad_pkg::CAP_W'(range / 3);
				3'h4: next_st.capacity = range >> 2;
				3'h5: next_st.capacity = emad_pkg::CAP_W'(range / 5);
				3'h6: next_st.capacity = emad_pkg::CAP_W'(range / 6);
				default: next_st.capacity = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cfg.capacity = st.capacity;
	assign cfg.accesses = st.accesses;

	a_rel_slot_cap: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.mode == emad_pkg::MODE_DRAM_REL8 && !cfg.bus_wide && cfg.word_len == emad_pkg::WL_12)
		|=> cfg.capacity == emad_pkg::CAP_REL_EX)
		else $error("Relative mode does not use a power-of-two slot.");
	a_abs_packed_cap: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.mode == emad_pkg::MODE_DRAM_ABS8 && !cfg.bus_wide && cfg.word_len == emad_pkg::WL_12)
		|=> cfg.capacity == emad_pkg::CAP_ABS_EX)
		else $error("Absolute mode does not pack words contiguously.");
	a_d24_rel_cap: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.mode == emad_pkg::MODE_DRAM_REL8 && !cfg.bus_wide
		&& cfg.word_len == emad_pkg::WL_16D24) |=> cfg.capacity == emad_pkg::CAP_D24_EX)
		else $error("The 16/24 code does not take the 24-bit relative capacity.");
	a_width_access: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.word_len == emad_pkg::WL_8 && cfg.mode == emad_pkg::MODE_SRAM_ABS)
		|=> cfg.accesses == ($past(cfg.bus_wide) ? 3'h1 : 3'h2))
		else $error("Access count does not follow the bus width.");
endmodule : emad_capacity

// [emad_top.sv]
// Addressing-mode decode, pin role selection and base post-increment for the memory port.
`timescale 1ns/1ps
module emad_top (
	input  wire logic                        CLK_SYS,
	input  wire logic                        RESETN,
	input  wire logic                        SOFT_RESET,
	input  wire logic                        CSR_WR,
	input  wire logic [emad_pkg::CSR_W-1:0]  CSR_WDATA,
	input  wire logic                        ACC_ACTIVE,
	input  wire logic [emad_pkg::ADDR_W-1:0] ACC_ADDR,
	input  wire logic                        ACC_DONE,
	input  wire logic                        POST_INC_EN,
	input  wire logic                        BASE_LOAD,
	input  wire logic [emad_pkg::ADDR_W-1:0] BASE_WDATA,
	input  wire logic                        ROW_REQ,
	input  wire logic                        COL_REQ,
	input  wire logic                        REFRESH_CYCLE,
	output logic [emad_pkg::CSR_W-1:0]       CSR_RDATA,
	output logic [emad_pkg::ADDR_W-1:0]      BASE_ADDR_REG,
	output logic                             BASE_INC,
	output logic                             WORD_DONE,
	output logic [3:0]                       MEM_CHIP_SEL_N,
	output logic                             MEM_ADDR_LINE_15,
	output logic                             MEM_ROW_STROBE_N,
	output logic                             MEM_COL_STROBE_N,
	output logic                             IS_DRAM,
	output logic                             IS_ABSOLUTE,
	output logic                             MODE_RESERVED,
	output logic [4:0]                       ADDR_LINE_COUNT,
	output logic [emad_pkg::CAP_W-1:0]       WORD_CAPACITY,
	output logic [2:0]                       ACCESSES_PER_WORD
);
	typedef struct packed {
		logic [3:0]                 addr_mode_sel;
		logic                       bus_width_sel;
		logic [2:0]                 word_len_sel;
		logic [emad_pkg::ADDR_W-1:0] base_addr_reg;
		logic [2:0]                 acc_cnt;
		logic                       base_inc;
		logic                       word_done;
		emad_pkg::emad_kind_e       kind;
		logic                       mode_rsv;
		logic [4:0]                 addr_lines;
		logic [3:0]                 chip_sel_n;
		logic                       addr_line_15;
		logic                       row_n;
		logic                       col_n;
		logic                       is_dram;
		logic                       is_abs;
	} emad_top_s;

	emad_top_s   st;
	emad_top_s   next_st;
	logic        last;
	logic        dram;
	emad_cap_if  cap ();

	assign cap.mode     = st.addr_mode_sel;
	assign cap.bus_wide = st.bus_width_sel;
	assign cap.word_len = st.word_len_sel;

	emad_capacity u_capacity (
		.clk   (CLK_SYS),
		.rst_n (RESETN),
		.cfg   (cap)
	);

	always_comb begin
		next_st = st;
		next_st.base_inc = 1'b0;
		next_st.word_done = 1'b0;
		if (CSR_WR) begin
			next_st.addr_mode_sel = CSR_WDATA[emad_pkg::MODE_MSB:emad_pkg::MODE_LSB];
			next_st.bus_width_sel = CSR_WDATA[emad_pkg::BW_BIT];
			next_st.word_len_sel = {CSR_WDATA[emad_pkg::WLEN2_BIT],
				CSR_WDATA[emad_pkg::WLEN1_BIT], CSR_WDATA[emad_pkg::WLEN0_BIT]};
		end
		// A zero access count (reserved setting) ends a word on every access.
		last = ({1'b0, st.acc_cnt} + 4'h1) >= {1'b0, cap.accesses};
		if (ACC_DONE) begin
			next_st.acc_cnt = last ? 3'h0 : st.acc_cnt + 3'h1;
			next_st.word_done = last;
			next_st.base_inc = POST_INC_EN && (st.kind == emad_pkg::KIND_SRAM_ABS
				|| st.kind == emad_pkg::KIND_DRAM_ABS || last);
		end
		// A load from software takes priority over a post-increment in the same cycle.
		if (BASE_LOAD) begin
			next_st.base_addr_reg = BASE_WDATA;
		end else if (next_st.base_inc) begin
			next_st.base_addr_reg = st.base_addr_reg + 24'h00_0001;
		end
		if (SOFT_RESET) begin
			next_st.addr_mode_sel = emad_pkg::MODE_RST;
			next_st.bus_width_sel = 1'b0;
			next_st.word_len_sel = emad_pkg::WL_RST;
			next_st.base_addr_reg = '0;
			next_st.acc_cnt = 3'h0;
			next_st.base_inc = 1'b0;
			next_st.word_done = 1'b0;
		end
		next_st.mode_rsv = 1'b0;
		next_st.chip_sel_n = 4'hF;
		next_st.addr_line_15 = 1'b0;
		next_st.addr_lines = 5'h00;
		next_st.kind = emad_pkg::KIND_SRAM_ABS;
		case (next_st.addr_mode_sel)
			emad_pkg::MODE_SRAM_ABS: begin
				next_st.addr_lines = emad_pkg::LINES_SRAM_ABS;
				next_st.addr_line_15 = 1'b1;
			end
			emad_pkg::MODE_SRAM_CS1: begin
				next_st.kind = emad_pkg::KIND_SRAM_REL;
				next_st.addr_lines = emad_pkg::LINES_SRAM_CS1;
				next_st.addr_line_15 = ACC_ADDR[emad_pkg::LINE15_BIT];
				next_st.chip_sel_n[0] = ~ACC_ACTIVE;
			end
			emad_pkg::MODE_SRAM_CS2: begin
				next_st.kind = emad_pkg::KIND_SRAM_REL;
				next_st.addr_lines = emad_pkg::LINES_SRAM_CS2;
				next_st.addr_line_15 = ACC_ADDR[emad_pkg::LINE15_BIT];
				next_st.chip_sel_n[ACC_ADDR[emad_pkg::CS2_SEL_BIT]] = ~ACC_ACTIVE;
			end
			emad_pkg::MODE_SRAM_CS4: begin
				next_st.kind = emad_pkg::KIND_SRAM_REL;
				next_st.addr_lines = emad_pkg::LINES_SRAM_CS4;
				next_st.chip_sel_n[ACC_ADDR[emad_pkg::CS4_SEL_LSB +: 2]] = ~ACC_ACTIVE;
			end
			default: begin
				if (next_st.addr_mode_sel[3:2] == emad_pkg::MODE_RSV_TOP) begin
					next_st.mode_rsv = 1'b1;
				end else begin
					// Dynamic RAM modes: no chip select, lines grow by one per step.
					next_st.kind = next_st.addr_mode_sel[3] ? emad_pkg::KIND_DRAM_ABS
						: emad_pkg::KIND_DRAM_REL;
					next_st.addr_lines = emad_pkg::LINES_DRAM_MIN
						+ {3'h0, next_st.addr_mode_sel[1:0]};
				end
			end
		endcase
		dram = next_st.kind == emad_pkg::KIND_DRAM_REL
			|| next_st.kind == emad_pkg::KIND_DRAM_ABS;
		next_st.is_dram = dram;
		next_st.is_abs = next_st.kind == emad_pkg::KIND_SRAM_ABS
			|| next_st.kind == emad_pkg::KIND_DRAM_ABS;
		// Static RAM modes keep the strobes for refresh of any dynamic parts on the bus.
		next_st.row_n = ~(ROW_REQ && !next_st.mode_rsv && (dram || REFRESH_CYCLE));
		next_st.col_n = ~(COL_REQ && !next_st.mode_rsv && (dram || REFRESH_CYCLE));
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			st <= '0;
			st.chip_sel_n <= 4'hF;
			st.addr_line_15 <= 1'b1;
			st.addr_lines <= emad_pkg::LINES_SRAM_ABS;
			st.row_n <= 1'b1;
			st.col_n <= 1'b1;
			st.is_abs <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		CSR_RDATA = '0;
		CSR_RDATA[emad_pkg::BW_BIT] = st.bus_width_sel;
		CSR_RDATA[emad_pkg::WLEN0_BIT] = st.word_len_sel[0];
		CSR_RDATA[emad_pkg::WLEN1_BIT] = st.word_len_sel[1];
		CSR_RDATA[emad_pkg::WLEN2_BIT] = st.word_len_sel[2];
		CSR_RDATA[emad_pkg::MODE_MSB:emad_pkg::MODE_LSB] = st.addr_mode_sel;
	end

	assign BASE_ADDR_REG     = st.base_addr_reg;
	assign BASE_INC          = st.base_inc;
	assign WORD_DONE         = st.word_done;
	assign MEM_CHIP_SEL_N    = st.chip_sel_n;
	assign MEM_ADDR_LINE_15  = st.addr_line_15;
	assign MEM_ROW_STROBE_N  = st.row_n;
	assign MEM_COL_STROBE_N  = st.col_n;
	assign IS_DRAM           = st.is_dram;
	assign IS_ABSOLUTE       = st.is_abs;
	assign MODE_RESERVED     = st.mode_rsv;
	assign ADDR_LINE_COUNT   = st.addr_lines;
	assign WORD_CAPACITY     = cap.capacity;
	assign ACCESSES_PER_WORD = cap.accesses;

	a_mode_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(CSR_WR && !SOFT_RESET) |=> CSR_RDATA[emad_pkg::MODE_MSB:emad_pkg::MODE_LSB]
		== $past(CSR_WDATA[emad_pkg::MODE_MSB:emad_pkg::MODE_LSB]))
		else $error("Mode field does not take the written bits.");
	a_soft_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		SOFT_RESET |=> CSR_RDATA == '0 && BASE_ADDR_REG == '0)
		else $error("Software reset does not clear the mode field.");
	a_abs_sram_pins: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(CSR_RDATA[emad_pkg::MODE_MSB:emad_pkg::MODE_LSB] == emad_pkg::MODE_SRAM_ABS)
		|-> MEM_CHIP_SEL_N == 4'hF && MEM_ADDR_LINE_15
		&& ADDR_LINE_COUNT == emad_pkg::LINES_SRAM_ABS && !IS_DRAM)
		else $error("Mode 0000 pins are not held high.");
	a_refresh_only: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(!IS_DRAM && (!MEM_ROW_STROBE_N || !MEM_COL_STROBE_N)) |-> $past(REFRESH_CYCLE))
		else $error("Strobe fired outside refresh in a static RAM mode.");
	a_dram_no_cs: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		IS_DRAM |-> MEM_CHIP_SEL_N == 4'hF && ADDR_LINE_COUNT >= emad_pkg::LINES_DRAM_MIN
		&& ADDR_LINE_COUNT <= emad_pkg::LINES_DRAM_MIN + 5'h03)
		else $error("Dynamic RAM mode drives a chip select.");
	a_abs_inc_each: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(ACC_DONE && POST_INC_EN && IS_ABSOLUTE && !BASE_LOAD && !SOFT_RESET)
		|=> BASE_INC && BASE_ADDR_REG == $past(BASE_ADDR_REG) + 24'h00_0001)
		else $error("Absolute mode missed a per-access increment.");
	a_rel_inc_word: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(ACC_DONE && !IS_ABSOLUTE && !last && !BASE_LOAD && !SOFT_RESET)
		|=> !BASE_INC && $stable(BASE_ADDR_REG))
		else $error("Relative mode incremented inside a word.");
	a_reserved_dark: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		MODE_RESERVED |-> (MEM_CHIP_SEL_N == 4'hF && MEM_ROW_STROBE_N && MEM_COL_STROBE_N)
		##1 (WORD_CAPACITY == '0))
		else $error("Reserved mode drives a memory pin.");
endmodule : emad_top

// [emad_mem_model.sv]
// Behavioural model of the static or dynamic RAM devices on the far side of the memory port.
`timescale 1ns/1ps
module emad_mem_model (
	input  wire logic        clk,
	input  wire logic [3:0]  chip_sel_n,
	input  wire logic        row_strobe_n,
	input  wire logic        gpio_enable,
	input  wire logic        is_dram,
	input  wire logic        bus_wide,
	output logic      [15:0] en_cycles,
	output logic      [15:0] strobe_cycles,
	output logic      [1:0]  dram_devices
);
	// A device with no select of its own can only be enabled by an outside pin.
	initial begin
		en_cycles = 16'h0000;
		forever begin
			@(posedge clk);
			if (!(&chip_sel_n) || gpio_enable) begin
				en_cycles <= en_cycles + 16'h0001;
			end
		end
	end
	initial begin
		strobe_cycles = 16'h0000;
		forever begin
			@(posedge clk);
			if (!row_strobe_n) begin
				strobe_cycles <= strobe_cycles + 16'h0001;
			end
		end
	end
	// Two nibble-wide parts sit side by side on the wide bus.
	assign dram_devices = !is_dram ? 2'h0 : (bus_wide ? 2'h2 : 2'h1);
endmodule : emad_mem_model

// [ext_mem_addr_mode_decode_tb.sv]
// Self-checking testbench for the addressing-mode decode block.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %0t got %0h expected %0h", $time, g, e); end end
module ext_mem_addr_mode_decode_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        soft_rst = 1'b0;
	logic        csr_we = 1'b0;
	logic        acc_active = 1'b0;
	logic        acc_done = 1'b0;
	logic        post_inc = 1'b0;
	logic        base_load = 1'b0;
	logic        row_req = 1'b0;
	logic        col_req = 1'b0;
	logic        refresh = 1'b0;
	logic        gpio_en = 1'b0;
	logic [23:0] csr_wdata = 24'h00_0000;
	logic [23:0] acc_addr = 24'h00_0000;
	logic [23:0] base_wdata = 24'h00_0000;
	logic [23:0] csr_rdata;
	logic [23:0] base_addr;
	logic        base_inc;
	logic        word_done;
	logic        is_dram;
	logic        is_abs;
	logic        mode_rsv;
	logic        row_n;
	logic        col_n;
	logic        line15;
	logic [3:0]  sel_n;
	logic [4:0]  lines;
	logic [22:0] cap;
	logic [2:0]  accs;
	logic [15:0] en_cnt;
	logic [15:0] str_cnt;
	logic [15:0] snap;
	logic [1:0]  devs;
	logic [3:0]  md;
	int          failures = 0;
	int          cmp_count = 0;

	always #2.5 clk = ~clk;

	emad_top u_dut (.CLK_SYS(clk), .RESETN(rst_n), .SOFT_RESET(soft_rst), .CSR_WR(csr_we),
		.CSR_WDATA(csr_wdata), .ACC_ACTIVE(acc_active), .ACC_ADDR(acc_addr),
		.ACC_DONE(acc_done), .POST_INC_EN(post_inc), .BASE_LOAD(base_load),
		.BASE_WDATA(base_wdata), .ROW_REQ(row_req), .COL_REQ(col_req),
		.REFRESH_CYCLE(refresh), .CSR_RDATA(csr_rdata), .BASE_ADDR_REG(base_addr),
		.BASE_INC(base_inc), .WORD_DONE(word_done), .MEM_CHIP_SEL_N(sel_n),
		.MEM_ADDR_LINE_15(line15), .MEM_ROW_STROBE_N(row_n), .MEM_COL_STROBE_N(col_n),
		.IS_DRAM(is_dram), .IS_ABSOLUTE(is_abs), .MODE_RESERVED(mode_rsv),
		.ADDR_LINE_COUNT(lines), .WORD_CAPACITY(cap), .ACCESSES_PER_WORD(accs));

	emad_mem_model u_mem (.clk(clk), .chip_sel_n(sel_n), .row_strobe_n(row_n),
		.gpio_enable(gpio_en), .is_dram(is_dram), .bus_wide(csr_rdata[0]),
		.en_cycles(en_cnt), .strobe_cycles(str_cnt), .dram_devices(devs));

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	task automatic hw_reset;
		rst_n = 1'b0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask : hw_reset

	// The extra edges let the registered capacity and access count follow the new mode.
	task automatic write_ctl(input logic [3:0] m, input logic bw, input logic [2:0] wl);
		logic [23:0] w;
		w = 24'h00_0000;
		w[emad_pkg::MODE_MSB:emad_pkg::MODE_LSB] = m;
		w[emad_pkg::BW_BIT] = bw;
		w[emad_pkg::WLEN0_BIT] = wl[0];
		w[emad_pkg::WLEN1_BIT] = wl[1];
		w[emad_pkg::WLEN2_BIT] = wl[2];
		@(negedge clk);
		csr_we = 1'b1;
		csr_wdata = w;
		@(negedge clk);
		csr_we = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(csr_rdata, csr_wdata)
	endtask : write_ctl

	task automatic chk_cap(input logic [3:0] m, input logic bw, input logic [2:0] wl,
		input logic [22:0] c, input logic [2:0] a);
		write_ctl(m, bw, wl);
		`CHK(cap, c)
		`CHK(accs, a)
	endtask : chk_cap

	task automatic pulse_done;
		@(negedge clk);
		acc_done = 1'b1;
		@(negedge clk);
		acc_done = 1'b0;
	endtask : pulse_done

	task automatic acc(input logic i, input logic d);
		pulse_done();
		`CHK(base_inc, i)
		`CHK(word_done, d)
	endtask : acc

	function automatic logic [3:0] exp_sel(input logic [3:0] m);
		case (m)
			4'h1: return 4'hE;
			4'h2: return 4'hD;
			4'h3: return 4'h7;
			default: return 4'hF;
		endcase
	endfunction : exp_sel

	function automatic logic [4:0] exp_lines(input logic [3:0] m);
		case (m)
			4'h0, 4'h3: return 5'h0F;
			4'h1: return 5'h12;
			4'h2: return 5'h11;
			default: return 5'h08 + {3'h0, m[1:0]};
		endcase
	endfunction : exp_lines

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("[FAIL] %0t run did not finish", $time);
		final_report();
	end

	initial begin
		hw_reset();
		`CHK(csr_rdata, 24'h00_0000)
		`CHK(sel_n, 4'hF)
		`CHK(line15, 1'b1)
		`CHK(cap, 23'h0_4000)
		$display("test reset done");
		acc_active = 1'b1;
		acc_addr = 24'h03_8000;
		for (int m = 0; m < 16; m++) begin
			md = 4'(m);
			write_ctl(md, 1'b0, emad_pkg::WL_8);
			`CHK(mode_rsv, md[3:2] == 2'b10)
			`CHK(is_dram, md[2])
			`CHK(sel_n, exp_sel(md))
			`CHK(line15, md <= 4'h2)
			if (md[3:2] != 2'b10) begin
				`CHK(is_abs, md == 4'h0 || md[3])
				`CHK(lines, exp_lines(md))
			end
		end
		$display("test modes done");
		write_ctl(4'h0, 1'b0, emad_pkg::WL_8);
		row_req = 1'b1;
		col_req = 1'b1;
		@(negedge clk);
		snap = str_cnt;
		repeat (4) @(negedge clk);
		`CHK(str_cnt, snap)
		`CHK(sel_n, 4'hF)
		snap = en_cnt;
		repeat (4) @(negedge clk);
		`CHK(en_cnt, snap)
		gpio_en = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(en_cnt, snap + 16'h0004)
		gpio_en = 1'b0;
		refresh = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(row_n, 1'b0)
		`CHK(col_n, 1'b0)
		refresh = 1'b0;
		write_ctl(4'hC, 1'b1, emad_pkg::WL_8);
		`CHK(row_n, 1'b0)
		`CHK(devs, 2'h2)
		write_ctl(4'h4, 1'b0, emad_pkg::WL_8);
		`CHK(col_n, 1'b0)
		`CHK(devs, 2'h1)
		row_req = 1'b0;
		col_req = 1'b0;
		acc_active = 1'b0;
		$display("test strobes done");
		chk_cap(4'h0, 1'b1, emad_pkg::WL_8, 23'h0_8000, 3'h1);
		chk_cap(4'h0, 1'b0, emad_pkg::WL_12, 23'h0_2AAA, 3'h3);
		chk_cap(4'hC, 1'b0, emad_pkg::WL_12, 23'h0_5555, 3'h3);
		chk_cap(4'hF, 1'b0, emad_pkg::WL_20, 23'hC_CCCC, 3'h5);
		chk_cap(4'h4, 1'b0, emad_pkg::WL_12, 23'h0_4000, 3'h3);
		chk_cap(4'h4, 1'b0, emad_pkg::WL_16, 23'h0_4000, 3'h4);
		chk_cap(4'hC, 1'b0, emad_pkg::WL_16D24, 23'h0_4000, 3'h4);
		chk_cap(4'h4, 1'b0, emad_pkg::WL_16D24, 23'h0_2000, 3'h4);
		chk_cap(4'hE, 1'b1, emad_pkg::WL_16D24, 23'h8_0000, 3'h2);
		chk_cap(4'h7, 1'b1, emad_pkg::WL_8, 23'h40_0000, 3'h1);
		chk_cap(4'hF, 1'b0, emad_pkg::WL_24, 23'hA_AAAA, 3'h6);
		chk_cap(4'h3, 1'b1, emad_pkg::WL_20, 23'h0_8000, 3'h3);
		chk_cap(4'h1, 1'b0, emad_pkg::WL_8, 23'h2_0000, 3'h2);
		chk_cap(4'h0, 1'b0, 3'h4, 23'h0_0000, 3'h0);
		chk_cap(4'h0, 1'b1, 3'h7, 23'h0_0000, 3'h0);
		chk_cap(4'h9, 1'b0, emad_pkg::WL_8, 23'h0_0000, 3'h0);
		chk_cap(4'h0, 1'b0, emad_pkg::WL_8, 23'h0_4000, 3'h2);
		$display("test capacity done");
		post_inc = 1'b1;
		base_wdata = 24'h00_0010;
		base_load = 1'b1;
		@(negedge clk);
		base_load = 1'b0;
		`CHK(base_addr, 24'h00_0010)
		acc(1'b1, 1'b0);
		acc(1'b1, 1'b1);
		`CHK(base_addr, 24'h00_0012)
		write_ctl(4'h4, 1'b0, emad_pkg::WL_8);
		acc(1'b0, 1'b0);
		acc(1'b1, 1'b1);
		`CHK(base_addr, 24'h00_0013)
		post_inc = 1'b0;
		pulse_done();
		pulse_done();
		`CHK(base_addr, 24'h00_0013)
		post_inc = 1'b1;
		write_ctl(4'h0, 1'b0, emad_pkg::WL_8);
		@(negedge clk);
		acc_done = 1'b1;
		base_load = 1'b1;
		base_wdata = 24'h00_0100;
		@(negedge clk);
		acc_done = 1'b0;
		base_load = 1'b0;
		`CHK(base_addr, 24'h00_0100)
		`CHK(base_inc, 1'b1)
		$display("test increment done");
		write_ctl(4'hF, 1'b1, emad_pkg::WL_24);
		soft_rst = 1'b1;
		@(negedge clk);
		soft_rst = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(csr_rdata, 24'h00_0000)
		`CHK(base_addr, 24'h00_0000)
		`CHK(cap, 23'h0_4000)
		write_ctl(4'h7, 1'b1, emad_pkg::WL_12);
		hw_reset();
		`CHK(csr_rdata, 24'h00_0000)
		`CHK(cap, 23'h0_4000)
		`CHK(is_abs, 1'b1)
		$display("test resets done");
		final_report();
	end
endmodule : ext_mem_addr_mode_decode_tb
